// file: logic/eight_bit_gpio_port.sv
// Purpose: Eight-pin general-purpose port with AXI4-Lite registers.
// Assumes: One clock; pins arrive asynchronously; lowPowerMode is synchronous.
// Notes:   Pad controls and peripheral inputs are registered outputs.
//
// Overview of operation
// - Direction one makes the pin an output.
// - Direction zero leaves the pin undriven input.
// - Data write updates latch and output pins.
// - Data write still updates latch on inputs.
// - Output pin reads return the latch.
// - Input reads pin; read-modify-write reads latch.
// - Peripheral drives claimed pin; reads see pin.
// - Peripheral input pin reads return pin level.
// - Reset clears all direction bits to zero.
// - Select one in standby: high-Z, inputs low.
// - Select zero in standby: pins unchanged.
// - Pull-up enabled unless pin driven low.
// - Open-drain high output becomes high impedance.
// - Debug pin pull-up bit stored, no effect.
// - Register bit n maps to pin n.
`default_nettype none

module eight_bit_gpio_port #(
    parameter logic [7:0] OPEN_DRAIN_MASK = 8'h00,  // Open-drain pins.
    parameter logic [7:0] NO_PULLUP_MASK  = 8'h04   // Debug input pin has no pull-up.
) (
    // Clock and reset.
    input  wire logic                       clk,
    input  wire logic                       srst,

    // AXI4-Lite write address.
    input  wire logic                       s_axi_awvalid,
    output var  logic                       s_axi_awready,
    input  wire logic [egp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,

    // AXI4-Lite write data.
    input  wire logic                       s_axi_wvalid,
    output var  logic                       s_axi_wready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,

    // AXI4-Lite write response.
    output var  logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output var  logic [1:0]                 s_axi_bresp,

    // AXI4-Lite read address.
    input  wire logic                       s_axi_arvalid,
    output var  logic                       s_axi_arready,
    input  wire logic [egp_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,

    // AXI4-Lite read data.
    output var  logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output var  logic [31:0]                s_axi_rdata,
    output var  logic [1:0]                 s_axi_rresp,

    // Power mode from the system controller.
    input  wire logic                       lowPowerMode,

    // Shared peripheral functions.
    input  wire logic [7:0]                 periphOe,
    input  wire logic [7:0]                 periphOut,
    output var  logic [7:0]                 periphIn,

    // Pads.
    input  wire logic [7:0]                 padIn,
    output var  logic [7:0]                 padOut,
    output var  logic [7:0]                 padOe,
    output var  logic [7:0]                 pullupOn
);

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        // Bus slave.
        logic                       awReady;   // Write address may be taken.
        logic                       awHave;    // Write address held.
        logic [egp_pkg::ADDR_W-1:0] awAddr;    // Held write address.
        logic                       wReady;    // Write data may be taken.
        logic                       wHave;     // Write data held.
        logic [7:0]                 wByte;     // Held low data byte.
        logic                       wLane;     // Low byte lane strobe.
        logic                       bValid;    // Write response pending.
        logic [1:0]                 bResp;     // Write response code.

        logic                       arReady;   // Read address may be taken.
        logic                       rValid;    // Read data pending.
        logic [31:0]                rData;     // Read data.
        logic [1:0]                 rResp;     // Read response code.

        // Port registers.
        logic [7:0]                 latch;     // Output data latch.
        logic [7:0]                 dir;       // Direction, one is output.
        logic [7:0]                 pull;      // Pull-up enables.
        logic                       stbySel;   // Standby pin state select.

        // Registered pad and peripheral outputs.
        logic [7:0]                 padOut;    // Pad output level.
        logic [7:0]                 padOe;     // Pad output enable.
        logic [7:0]                 pullOn;    // Pull-up connection.
        logic [7:0]                 periphIn;  // Level seen by peripherals.
    } egp_state_t;

    egp_state_t st_reg;   // Current state.
    egp_state_t st_next;  // Next state.

    // ****************************************************************
    // Helper functions.
    // ****************************************************************

    // True when the address names a register of the port.
    function automatic logic egpMapped(input logic [egp_pkg::ADDR_W-1:0] a);
        egpMapped = (a == egp_pkg::OFF_DATA) || (a == egp_pkg::OFF_DIR) ||
                    (a == egp_pkg::OFF_PULL) || (a == egp_pkg::OFF_STBY) ||
                    (a == egp_pkg::OFF_LATCH);
    endfunction : egpMapped

    // Widens an eight-bit field to a bus word with zero upper bits.
    function automatic logic [31:0] egpWord(input logic [7:0] v);
        egpWord = {24'h000000, v};
    endfunction : egpWord

    // ****************************************************************
    // Pin input path.
    // ****************************************************************
    logic [7:0] pinLevel;    // Synchronised pin levels.
    logic       standbyHiz;  // Pins released and inputs blocked.
    logic [7:0] inputView;   // Pin level after standby blocking.
    logic [7:0] dataView;    // Ordinary data register read value.

    egp_pin_sync #(
        .WIDTH (8)
    ) u_sync (
        .clk    (clk),
        .srst   (srst),
        .rawIn  (padIn),
        .level  (pinLevel)
    );

    // Work out standby blocking and the ordinary read view of each pin.
    always_comb begin
        standbyHiz = st_reg.stbySel & lowPowerMode;

        inputView  = standbyHiz ? 8'h00 : pinLevel;

        dataView   = (st_reg.dir & ~periphOe & st_reg.latch) | (~(st_reg.dir & ~periphOe) & inputView);
    end

    // ****************************************************************
    // Pad control.
    // ****************************************************************
    logic [7:0] padOutNext;  // Pad level for next cycle.
    logic [7:0] padOeNext;   // Pad enable for next cycle.
    logic [7:0] pullOnNext;  // Pull-up for next cycle.

    egp_pad_ctrl #(
        .OPEN_DRAIN_MASK (OPEN_DRAIN_MASK),
        .NO_PULLUP_MASK  (NO_PULLUP_MASK)
    ) u_pad (
        .standbyHiz (standbyHiz),
        .dirBits    (st_reg.dir),
        .latchBits  (st_reg.latch),
        .pullEn     (st_reg.pull),
        .periphOe   (periphOe),
        .periphOut  (periphOut),
        .padOut     (padOutNext),
        .padOe      (padOeNext),
        .pullOn     (pullOnNext)
    );

    // ****************************************************************
    // Next state.
    // ****************************************************************

    // Bus handshakes, register writes, read answers and pad outputs.
    always_comb begin
        logic doWrite;  // Both halves of a write are held.
        logic doRead;   // A read address is taken.

        doWrite = 1'b0;
        doRead  = 1'b0;
        st_next = st_reg;

        // Take the write address and data independently.
        if (s_axi_awvalid && st_reg.awReady) begin
            st_next.awHave = 1'b1;
            st_next.awAddr = s_axi_awaddr;
        end

        if (s_axi_wvalid && st_reg.wReady) begin
            st_next.wHave = 1'b1;
            st_next.wByte = s_axi_wdata[7:0];
            st_next.wLane = s_axi_wstrb[0];
        end

        // Retire an answered write response.
        if (st_reg.bValid && s_axi_bready) begin
            st_next.bValid = 1'b0;
        end

        // Perform a write once both halves are held and no answer waits.
        doWrite = st_reg.awHave && st_reg.wHave && !st_reg.bValid;
        if (doWrite) begin
            st_next.awHave = 1'b0;
            st_next.wHave  = 1'b0;
            st_next.bValid = 1'b1;
            st_next.bResp  = egpMapped(st_reg.awAddr) ? egp_pkg::RESP_OKAY : egp_pkg::RESP_SLVERR;
            if (st_reg.wLane) begin
                case (st_reg.awAddr)
                    egp_pkg::OFF_DATA: begin
                        st_next.latch = st_reg.wByte;
                    end

                    egp_pkg::OFF_DIR: begin
                        st_next.dir = st_reg.wByte;
                    end

                    egp_pkg::OFF_PULL: begin
                        st_next.pull = st_reg.wByte;
                    end

                    egp_pkg::OFF_STBY: begin
                        st_next.stbySel = st_reg.wByte[egp_pkg::STBY_SEL_BIT];
                    end

                    default: begin
                        // Latch view and unmapped words take no write.
                        st_next.latch = st_reg.latch;
                    end
                endcase
            end
        end

        // Accept a new write half only while that half is not held and no answer is pending.
        st_next.awReady = !st_next.awHave && !st_next.bValid;
        st_next.wReady  = !st_next.wHave && !st_next.bValid;

        // Retire an answered read.
        if (st_reg.rValid && s_axi_rready) begin
            st_next.rValid = 1'b0;
        end

        // Take a read address and build the answer.
        doRead = s_axi_arvalid && st_reg.arReady;
        if (doRead) begin
            st_next.rValid = 1'b1;
            st_next.rResp  = egpMapped(s_axi_araddr) ? egp_pkg::RESP_OKAY : egp_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                egp_pkg::OFF_DATA: begin
                    st_next.rData = egpWord(dataView);
                end

                egp_pkg::OFF_LATCH: begin
                    st_next.rData = egpWord(st_reg.latch);
                end

                egp_pkg::OFF_DIR: begin
                    st_next.rData = egpWord(st_reg.dir);
                end

                egp_pkg::OFF_PULL: begin
                    st_next.rData = egpWord(st_reg.pull);
                end

                egp_pkg::OFF_STBY: begin
                    st_next.rData = egpWord({7'h00, st_reg.stbySel});
                end

                default: begin
                    // Unmapped words read as zero.
                    st_next.rData = 32'h00000000;
                end
            endcase
        end

        st_next.arReady = !st_next.rValid;

        // Register the pad and peripheral views.
        st_next.padOut   = padOutNext;
        st_next.padOe    = padOeNext;
        st_next.pullOn   = pullOnNext;
        st_next.periphIn = inputView;
    end

    // ****************************************************************
    // State register.
    // ****************************************************************

    // Register the state; reset releases every pad and clears directions.
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg         <= '0;

            st_reg.latch   <= egp_pkg::DATA_RST;
            st_reg.dir     <= egp_pkg::DIR_RST;
            st_reg.pull    <= egp_pkg::PULL_RST;
            st_reg.stbySel <= egp_pkg::STBY_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs, all straight from the state register.
    // ****************************************************************
    assign s_axi_awready = st_reg.awReady;
    assign s_axi_wready  = st_reg.wReady;
    assign s_axi_bvalid  = st_reg.bValid;
    assign s_axi_bresp   = st_reg.bResp;
    assign s_axi_arready = st_reg.arReady;
    assign s_axi_rvalid  = st_reg.rValid;
    assign s_axi_rdata   = st_reg.rData;
    assign s_axi_rresp   = st_reg.rResp;

    assign padOut        = st_reg.padOut;
    assign padOe         = st_reg.padOe;
    assign pullupOn      = st_reg.pullOn;
    assign periphIn      = st_reg.periphIn;

endmodule : eight_bit_gpio_port

`default_nettype wire

// file: logic/egp_pkg.sv
// Purpose: Shared constants for the eight-pin general-purpose port.
// Assumes: A 32-bit AXI4-Lite register bus with byte addresses.
// Notes:   Offsets, reset values and bus answers live here only.
`default_nettype none

package egp_pkg;

    // ****************************************************************
    // Widths.
    // ****************************************************************
    localparam int unsigned ADDR_W = 5;   // Byte address bits decoded.
    localparam int unsigned DATA_W = 32;  // Bus data width.
    localparam int unsigned PINS   = 8;   // Pins in the port.

    // ****************************************************************
    // Register offsets (byte addresses).
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFF_DATA  = 5'h00;  // Pin or latch view.
    localparam logic [ADDR_W-1:0] OFF_DIR   = 5'h04;  // Direction bits.
    localparam logic [ADDR_W-1:0] OFF_PULL  = 5'h08;  // Pull-up enables.
    localparam logic [ADDR_W-1:0] OFF_STBY  = 5'h0c;  // Standby pin state select.
    localparam logic [ADDR_W-1:0] OFF_LATCH = 5'h10;  // Read-modify-write view.

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int unsigned STBY_SEL_BIT = 0;  // Standby pin state select bit.

    // ****************************************************************
    // Values after reset.
    // ****************************************************************
    localparam logic [7:0] DATA_RST = 8'h00;  // Output latch.
    localparam logic [7:0] DIR_RST  = 8'h00;  // All pins inputs.
    localparam logic [7:0] PULL_RST = 8'h00;  // Pull-ups off.
    localparam logic       STBY_RST = 1'b0;   // Pins hold in standby.

    // ****************************************************************
    // Bus answers.
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;  // Access done.
    localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped address.

endpackage : egp_pkg

`default_nettype wire

// file: logic/egp_pin_sync.sv
// Purpose: Brings the asynchronous pin levels into the clock domain.
// Assumes: Pins may change at any time relative to clk.
// Notes:   A change counts once the second and third stages agree.
`default_nettype none

module egp_pin_sync #(
    parameter int unsigned WIDTH = 8  // Number of pins.
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             srst,
    // Raw and filtered levels.
    input  wire logic [WIDTH-1:0] rawIn,
    output var  logic [WIDTH-1:0] level
);

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        logic [WIDTH-1:0] s1;   // First stage, read by s2 only.
        logic [WIDTH-1:0] s2;   // Second stage.
        logic [WIDTH-1:0] s3;   // Third stage.
        logic [WIDTH-1:0] lvl;  // Accepted level.
    } egp_sync_t;

    egp_sync_t st_reg;   // Current state.
    egp_sync_t st_next;  // Next state.

    // Shift the stages; accept a level once stages two and three agree.
    always_comb begin
        st_next     = st_reg;
        st_next.s1  = rawIn;
        st_next.s2  = st_reg.s1;
        st_next.s3  = st_reg.s2;
        st_next.lvl = (st_reg.s2 & st_reg.s3) | (st_reg.lvl & (st_reg.s2 | st_reg.s3));
    end

    // Register the state; reset clears every stage.
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.lvl;

endmodule : egp_pin_sync

`default_nettype wire

// file: logic/egp_pad_ctrl.sv
// Purpose: Works out drive, enable and pull-up for each pad.
// Assumes: Inputs are registered state of the same clock.
// Notes:   Pure logic; the caller registers the results.
`default_nettype none

module egp_pad_ctrl #(
    parameter logic [7:0] OPEN_DRAIN_MASK = 8'h00,  // Pins with N-channel open drain.
    parameter logic [7:0] NO_PULLUP_MASK  = 8'h04   // Pins without a pull-up.
) (
    // Configuration.
    input  wire logic       standbyHiz,
    input  wire logic [7:0] dirBits,
    input  wire logic [7:0] latchBits,
    input  wire logic [7:0] pullEn,
    // Peripheral outputs.
    input  wire logic [7:0] periphOe,
    input  wire logic [7:0] periphOut,
    // Pad controls.
    output var  logic [7:0] padOut,
    output var  logic [7:0] padOe,
    output var  logic [7:0] pullOn
);

    // Choose the source for each pad and apply open-drain and pull-up rules.
    always_comb begin
        logic [7:0] src;  // Level the pad would drive.
        logic [7:0] act;  // Pad is driven by port or peripheral.
        src = '0;
        act = '0;
        src = (periphOe & periphOut) | (~periphOe & latchBits);
        act = periphOe | dirBits;
        if (standbyHiz) begin
            act = '0;
        end
        padOe  = act & ~(OPEN_DRAIN_MASK & src);
        padOut = src & ~OPEN_DRAIN_MASK;
        pullOn = pullEn & ~NO_PULLUP_MASK & ~(padOe & ~padOut);
    end

endmodule : egp_pad_ctrl

`default_nettype wire

// file: tb/egp_checker.sv
// Purpose: Port-level assertions for the gpio block.
// Assumes: Default masks; aw and w offered together.
// Notes:   Bound after the module.
`default_nettype none
module egp_checker (
    // Clock and reset.
    input wire logic                       clk,
    input wire logic                       srst,
    // Register bus.
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_bready,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic [egp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready,
    input wire logic [31:0]                s_axi_rdata,
    input wire logic [1:0]                 s_axi_rresp,
    // Pins and peripherals.
    input wire logic                       lowPowerMode,
    input wire logic [7:0]                 periphOe,
    input wire logic [7:0]                 periphOut,
    input wire logic [7:0]                 padOut,
    input wire logic [7:0]                 padOe,
    input wire logic [7:0]                 pullupOn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Both halves of a write taken at one edge.
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // The answer follows one quiet cycle.
    sequence s_wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    chk_write_answer: assert property (s_wr_take |=> s_wr_answer)
        else $error("write answer not on time");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not on time");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h10
        |=> s_axi_rresp == egp_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    chk_pull_low_off: assert property ((pullupOn & padOe & ~padOut) == 8'h00)
        else $error("pull-up on a pin driven low");
    chk_debug_pull: assert property (!pullupOn[2])
        else $error("pull-up on debug pin");
    chk_periph_drive: assert property (!lowPowerMode |=> ((padOe & $past(periphOe)) == $past(periphOe))
        && (((padOut ^ $past(periphOut)) & $past(periphOe)) == 8'h00)) else $error("peripheral not driving");
endmodule : egp_checker
bind eight_bit_gpio_port egp_checker chk_u (
    .clk(clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .lowPowerMode(lowPowerMode),
    .periphOe(periphOe), .periphOut(periphOut), .padOut(padOut), .padOe(padOe), .pullupOn(pullupOn)
);
`default_nettype wire

// file: tb/egp_board_model.sv
// Purpose: Board seen by the gpio pads.
// Assumes: Port drive wins, then outside drive, then the pull-up.
// Notes:   A floating pin reads high with its pull-up on, else the inverse of padOut.
`default_nettype none
module egp_board_model (
    // Pad controls from the port.
    input  wire logic [7:0] padOut,
    input  wire logic [7:0] padOe,
    input  wire logic [7:0] pullupOn,
    // Outside drivers.
    input  wire logic [7:0] extLevel,
    input  wire logic [7:0] extDrive,
    // Resolved pin levels.
    output var  logic [7:0] padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Resolves each wire from every party that may drive it.
    always_comb begin
        padIn = (padOe & padOut) | (~padOe & extDrive & extLevel) | (~padOe & ~extDrive & (pullupOn | ~padOut));
    end
endmodule : egp_board_model
`default_nettype wire

// file: tb/eight_bit_gpio_port_test.sv
// Purpose: Register and pin checks of the gpio block.
// Assumes: Pin 0 open drain; bus answers as in package.
// Notes:   Pads are read at edges.
`default_nettype none
module eight_bit_gpio_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, srst, lowPowerMode, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [7:0]  periphOe, periphOut, periphIn, padIn, padOut, padOe, pullupOn, extLevel, extDrive;
    int          err_count, check_count, cycles;
    eight_bit_gpio_port #(.OPEN_DRAIN_MASK(8'h01)) dut_u (
        .clk(clk), .srst(srst), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .lowPowerMode(lowPowerMode), .periphOe(periphOe), .periphOut(periphOut), .periphIn(periphIn),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .pullupOn(pullupOn)
    );
    egp_board_model model_u (.padOut(padOut), .padOe(padOe), .pullupOn(pullupOn), .extLevel(extLevel),
        .extDrive(extDrive), .padIn(padIn));
    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            complete_run();
        end
    end
    // Counts and reports one comparison.
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // One write; address and data offered together.
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge clk);
            if (awready && !awDone) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !wDone) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge clk);
        bready <= 1'b0;
        cmp("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge clk);
    endtask : wr
    // One read with expected data and answer.
    task automatic rd(input logic [4:0] a, input logic [7:0] ed, input logic [1:0] er, input string n);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        cmp(n, {24'h0, ed}, rdata);
        cmp("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge clk);
    endtask : rd
    // Prints the counts and the verdict.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    // Main sequence.
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready, lowPowerMode} = 7'h40;
        {awaddr, araddr, wdata, cycles, err_count, check_count} = '0;
        periphOe = 8'h00;
        periphOut = 8'h80;
        extLevel = 8'h3c;
        extDrive = 8'hff;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(egp_pkg::OFF_DIR, 8'h00, egp_pkg::RESP_OKAY, "dir");
        wr(egp_pkg::OFF_DATA, 8'ha5, egp_pkg::RESP_OKAY);
        cmp("oe idle", 32'h0, {24'h0, padOe});
        rd(egp_pkg::OFF_LATCH, 8'ha5, egp_pkg::RESP_OKAY, "latch");
        rd(egp_pkg::OFF_DATA, 8'h3c, egp_pkg::RESP_OKAY, "pins");
        extDrive <= 8'hf0;
        wr(egp_pkg::OFF_DIR, 8'h0f, egp_pkg::RESP_OKAY);
        cmp("oe out", 32'h0e, {24'h0, padOe});
        cmp("out", 32'h04, {24'h0, padOut & 8'h0f});
        rd(egp_pkg::OFF_DATA, 8'h35, egp_pkg::RESP_OKAY, "mixed");
        wr(egp_pkg::OFF_DATA, 8'h5a, egp_pkg::RESP_OKAY);
        cmp("out new", 32'h0a, {24'h0, padOut & 8'h0f});
        wr(egp_pkg::OFF_PULL, 8'hff, egp_pkg::RESP_OKAY);
        cmp("pull", 32'hfa, {24'h0, pullupOn});
        rd(egp_pkg::OFF_PULL, 8'hff, egp_pkg::RESP_OKAY, "pull reg");
        periphOe <= 8'h80;
        extDrive <= 8'h70;
        repeat (8) @(posedge clk);
        cmp("oe periph", 32'h8f, {24'h0, padOe});
        cmp("periph in", 32'hba, {24'h0, periphIn});
        rd(egp_pkg::OFF_DATA, 8'hba, egp_pkg::RESP_OKAY, "periph pin");
        rd(egp_pkg::OFF_LATCH, 8'h5a, egp_pkg::RESP_OKAY, "periph rmw");
        lowPowerMode <= 1'b1;
        repeat (2) @(posedge clk);
        cmp("oe hold", 32'h8f, {24'h0, padOe});
        wr(egp_pkg::OFF_STBY, 8'h01, egp_pkg::RESP_OKAY);
        cmp("oe hiz", 32'h0, {24'h0, padOe});
        rd(egp_pkg::OFF_DATA, 8'h0a, egp_pkg::RESP_OKAY, "blocked");
        cmp("in blocked", 32'h0, {24'h0, periphIn});
        lowPowerMode <= 1'b0;
        periphOe <= 8'h00;
        wr(egp_pkg::OFF_LATCH, 8'h00, egp_pkg::RESP_OKAY);
        rd(egp_pkg::OFF_LATCH, 8'h5a, egp_pkg::RESP_OKAY, "rmw kept");
        rd(egp_pkg::OFF_STBY, 8'h01, egp_pkg::RESP_OKAY, "stby");
        rd(5'h14, 8'h00, egp_pkg::RESP_SLVERR, "unmapped");
        wr(5'h18, 8'hff, egp_pkg::RESP_SLVERR);
        complete_run();
    end
endmodule : eight_bit_gpio_port_test
`default_nettype wire
